// >>> src/irq_priority_status_and_service_clear.sv
// Interrupt rank status, service tracking and service clear with APB access
`timescale 1ns/1ps
`default_nettype none
module irq_priority_status_and_service_clear (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Interrupt sources and requests to the core
    input wire logic [25:0] src_irq_in,
    output logic irq_out,
    output logic fast_irq_out
);

    localparam int GROUPS = 4;

    // Register state
    logic [31:0] prog_group_rank_reg;
    logic [12:0] prog_master_reg;
    logic [31:0] cur_group_rank_reg;
    logic [7:0] cur_master_rank_reg;
    logic [25:0] pending_reg;
    logic [25:0] enable_mask_reg;
    logic [25:0] fast_select_reg;
    logic [25:0] service_reg;
    logic [5:0] vector_reg;
    logic [1:0] served_group_reg;
    logic [1:0] served_slot_reg;
    logic served_grouped_reg;
    irq_status_pkg::service_state_type state_reg;

    // Bus outputs and interrupt lines
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic fast_irq_reg;

    // Decoded bus events
    logic write_take;
    logic normal_clear_hit;
    logic fast_clear_hit;
    logic [25:0] clear_bits;
    logic service_end;

    // Arbitration
    logic [25:0] normal_req;
    logic [3:0] group_grant [GROUPS];
    logic [3:0] group_any;
    logic [7:0] group_rotated [GROUPS];
    logic [3:0] master_grant;
    logic master_any;
    logic [7:0] master_rotated;
    logic win_valid;
    logic win_grouped;
    logic [4:0] win_idx;
    logic [1:0] win_group;
    logic [1:0] win_slot;

    function automatic logic [1:0] onehot_index(input logic [3:0] onehot);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (onehot[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    // Slot interfaces: entries 0..3 are groups A..D, entry 4 is the master level
    rank_slot_if slot_if [GROUPS + 1] ();

    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : group_slot
            assign slot_if[g].rank = cur_group_rank_reg[(3 - g) * 8 +: 8];
            // Request and grant bits are indexed by slot A..D, as the rank fields are
            assign slot_if[g].req = {normal_req[irq_status_pkg::GROUP_SRC[g][3]],
                                     normal_req[irq_status_pkg::GROUP_SRC[g][2]],
                                     normal_req[irq_status_pkg::GROUP_SRC[g][1]],
                                     normal_req[irq_status_pkg::GROUP_SRC[g][0]]};
            assign slot_if[g].served = served_slot_reg;
            assign group_grant[g] = slot_if[g].grant;
            assign group_any[g] = slot_if[g].any;
            assign group_rotated[g] = slot_if[g].rotated;
            rank_arbiter group_arb (
                .slot(slot_if[g])
            );
            rank_rotator group_rot (
                .slot(slot_if[g])
            );
        end
    endgenerate

    assign slot_if[GROUPS].rank = cur_master_rank_reg;
    assign slot_if[GROUPS].req = group_any;
    assign slot_if[GROUPS].served = served_group_reg;
    assign master_grant = slot_if[GROUPS].grant;
    assign master_any = slot_if[GROUPS].any;
    assign master_rotated = slot_if[GROUPS].rotated;

    rank_arbiter master_arb (
        .slot(slot_if[GROUPS])
    );
    rank_rotator master_rot (
        .slot(slot_if[GROUPS])
    );

    // Bus decode; a write lands on the access edge that sees pready high
    assign write_take = psel_in && penable_in && pready_reg && pwrite_in;
    assign normal_clear_hit = write_take && paddr_in == irq_status_pkg::ADDR_NORMAL_CLEAR;
    assign fast_clear_hit = write_take && paddr_in == irq_status_pkg::ADDR_FAST_CLEAR;
    assign clear_bits = (normal_clear_hit || fast_clear_hit) ? pwdata_in[25:0] : 26'h0;
    assign service_end = normal_clear_hit || fast_clear_hit;

    // Fast sources never compete for the service word
    assign normal_req = pending_reg & enable_mask_reg & ~fast_select_reg;

    // Winner: grouped sources by master then group rank, then ungrouped by bit
    always_comb begin
        logic [1:0] grp;
        logic [1:0] slt;
        grp = onehot_index(master_grant);
        slt = onehot_index(group_grant[grp]);
        win_valid = 1'b0;
        win_grouped = 1'b0;
        win_idx = 5'h00;
        win_group = grp;
        win_slot = slt;
        if (master_any) begin
            win_valid = 1'b1;
            win_grouped = 1'b1;
            win_idx = irq_status_pkg::GROUP_SRC[grp][slt];
        end else begin
            for (int i = 0; i < irq_status_pkg::SRC_COUNT; i++) begin
                if (normal_req[i] && irq_status_pkg::UNGROUPED_MASK[i]) begin
                    win_valid = 1'b1;
                    win_idx = 5'(i);
                end
            end
        end
    end

    // Programmed ranks and modes
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prog_group_rank_reg <= irq_status_pkg::RST_GROUP_RANK;
            prog_master_reg <= irq_status_pkg::RST_PROG_MASTER;
        end else if (write_take && paddr_in == irq_status_pkg::ADDR_PROG_GROUP_RANK) begin
            prog_group_rank_reg <= pwdata_in;
        end else if (write_take && paddr_in == irq_status_pkg::ADDR_PROG_MASTER_RANK) begin
            prog_master_reg <= pwdata_in[12:0];
        end
    end

    // Masks and fast selection
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_mask_reg <= 26'h0;
            fast_select_reg <= 26'h0;
        end else if (write_take && paddr_in == irq_status_pkg::ADDR_ENABLE_MASK) begin
            enable_mask_reg <= pwdata_in[25:0];
        end else if (write_take && paddr_in == irq_status_pkg::ADDR_FAST_SELECT) begin
            fast_select_reg <= pwdata_in[25:0];
        end
    end

    // Pending flags: a high source line in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pending_reg <= 26'h0;
        end else begin
            pending_reg <= (pending_reg & ~clear_bits) | src_irq_in;
        end
    end

    // Current group ranks
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur_group_rank_reg <= irq_status_pkg::RST_GROUP_RANK;
        end else begin
            for (int i = 0; i < GROUPS; i++) begin
                if (prog_master_reg[irq_status_pkg::GROUP_MODE_LSB + 3 - i]) begin
                    cur_group_rank_reg[(3 - i) * 8 +: 8] <=
                        prog_group_rank_reg[(3 - i) * 8 +: 8];
                end else if (write_take && paddr_in == irq_status_pkg::ADDR_PROG_GROUP_RANK) begin
                    cur_group_rank_reg[(3 - i) * 8 +: 8] <= pwdata_in[(3 - i) * 8 +: 8];
                end else if (service_end && state_reg == irq_status_pkg::SVC_BUSY
                             && served_grouped_reg && served_group_reg == 2'(i)) begin
                    cur_group_rank_reg[(3 - i) * 8 +: 8] <= group_rotated[i];
                end
            end
        end
    end

    // Current master ranks
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur_master_rank_reg <= irq_status_pkg::RST_RANK_BYTE;
        end else if (prog_master_reg[irq_status_pkg::MASTER_MODE_BIT]) begin
            cur_master_rank_reg <= prog_master_reg[7:0];
        end else if (write_take && paddr_in == irq_status_pkg::ADDR_PROG_MASTER_RANK) begin
            cur_master_rank_reg <= pwdata_in[7:0];
        end else if (service_end && state_reg == irq_status_pkg::SVC_BUSY
                     && served_grouped_reg) begin
            cur_master_rank_reg <= master_rotated;
        end
    end

    // Service tracking: one source at a time, ended only by a clear write
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= irq_status_pkg::SVC_IDLE;
            service_reg <= irq_status_pkg::RST_SERVICE;
            vector_reg <= 6'h00;
            served_group_reg <= 2'h0;
            served_slot_reg <= 2'h0;
            served_grouped_reg <= 1'b0;
        end else begin
            case (state_reg)
                irq_status_pkg::SVC_IDLE: begin
                    if (win_valid && !service_end) begin
                        service_reg <= 26'h1 << win_idx;
                        vector_reg <= {1'b0, win_idx};
                        served_group_reg <= win_group;
                        served_slot_reg <= win_slot;
                        served_grouped_reg <= win_grouped;
                        state_reg <= irq_status_pkg::SVC_BUSY;
                    end
                end
                irq_status_pkg::SVC_BUSY: begin
                    if (service_end) begin
                        service_reg <= 26'h0;
                        state_reg <= irq_status_pkg::SVC_IDLE;
                    end
                end
                default: begin
                    state_reg <= irq_status_pkg::SVC_IDLE;
                end
            endcase
        end
    end

    // Interrupt lines: unmasked pending flags of each kind
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_reg <= 1'b0;
            fast_irq_reg <= 1'b0;
        end else begin
            irq_reg <= |normal_req;
            fast_irq_reg <= |(pending_reg & enable_mask_reg & fast_select_reg);
        end
    end

    // APB answer: data is sampled in the setup cycle, ready in the first access cycle
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= psel_in && !penable_in;
            // Error stands only with ready; the read data holds until the next setup cycle
            pslverr_reg <= 1'b0;
            if (psel_in && !penable_in) begin
                prdata_reg <= 32'h0;
                if (paddr_in == irq_status_pkg::ADDR_PROG_GROUP_RANK) begin
                    prdata_reg <= prog_group_rank_reg;
                end else if (paddr_in == irq_status_pkg::ADDR_PROG_MASTER_RANK) begin
                    prdata_reg <= {19'h0, prog_master_reg};
                end else if (paddr_in == irq_status_pkg::ADDR_CUR_GROUP_RANK) begin
                    prdata_reg <= cur_group_rank_reg;
                end else if (paddr_in == irq_status_pkg::ADDR_CUR_MASTER_RANK) begin
                    prdata_reg <= {16'h0, 2'h0, vector_reg, cur_master_rank_reg};
                end else if (paddr_in == irq_status_pkg::ADDR_SERVICE) begin
                    prdata_reg <= {6'h0, service_reg};
                end else if (paddr_in == irq_status_pkg::ADDR_NORMAL_CLEAR) begin
                    prdata_reg <= 32'h0;
                end else if (paddr_in == irq_status_pkg::ADDR_FAST_CLEAR) begin
                    prdata_reg <= 32'h0;
                end else if (paddr_in == irq_status_pkg::ADDR_PENDING) begin
                    prdata_reg <= {6'h0, pending_reg};
                end else if (paddr_in == irq_status_pkg::ADDR_ENABLE_MASK) begin
                    prdata_reg <= {6'h0, enable_mask_reg};
                end else if (paddr_in == irq_status_pkg::ADDR_FAST_SELECT) begin
                    prdata_reg <= {6'h0, fast_select_reg};
                end else begin
                    pslverr_reg <= 1'b1;
                end
            end
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign irq_out = irq_reg;
    assign fast_irq_out = fast_irq_reg;

endmodule
`default_nettype wire

// >>> src/irq_status_pkg.sv
// Shared constants for the interrupt rank status and service clear block
package irq_status_pkg;

    localparam int SRC_COUNT = 26;
    localparam int VECTOR_W = 6;

    // Register byte addresses
    localparam logic [31:0] ADDR_PROG_GROUP_RANK = 32'h01e00010;
    localparam logic [31:0] ADDR_PROG_MASTER_RANK = 32'h01e00014;
    localparam logic [31:0] ADDR_CUR_GROUP_RANK = 32'h01e00018;
    localparam logic [31:0] ADDR_CUR_MASTER_RANK = 32'h01e0001c;
    localparam logic [31:0] ADDR_SERVICE = 32'h01e00020;
    localparam logic [31:0] ADDR_NORMAL_CLEAR = 32'h01e00024;
    localparam logic [31:0] ADDR_FAST_CLEAR = 32'h01e0003c;
    localparam logic [31:0] ADDR_PENDING = 32'h01e00040;
    localparam logic [31:0] ADDR_ENABLE_MASK = 32'h01e00044;
    localparam logic [31:0] ADDR_FAST_SELECT = 32'h01e00048;

    // Reset values
    localparam logic [31:0] RST_GROUP_RANK = 32'h1b1b1b1b;
    localparam logic [7:0] RST_RANK_BYTE = 8'h1b;
    localparam logic [12:0] RST_PROG_MASTER = 13'h1f1b;
    localparam logic [25:0] RST_SERVICE = 26'h0000000;

    // Master word fields and the lowest rank code
    localparam int MASTER_MODE_BIT = 12;
    localparam int GROUP_MODE_LSB = 8;
    localparam int VECTOR_LSB = 8;
    localparam logic [1:0] RANK_LOWEST = 2'h3;

    // Sources outside the four groups, served after every grouped source
    localparam logic [25:0] UNGROUPED_MASK = 26'h030c30f;

    // Source bit of each slot, group A..D by slot A..D
    localparam logic [4:0] GROUP_SRC [4][4] = '{
        '{5'h19, 5'h18, 5'h17, 5'h16},
        '{5'h13, 5'h12, 5'h11, 5'h10},
        '{5'h0d, 5'h0c, 5'h0b, 5'h0a},
        '{5'h07, 5'h06, 5'h05, 5'h04}
    };

    typedef enum logic {
        SVC_IDLE,
        SVC_BUSY
    } service_state_type;

endpackage

// >>> src/rank_slot_if.sv
// Signals between the controller and one rank arbiter and rotator pair
`timescale 1ns/1ps
`default_nettype none
interface rank_slot_if;
    logic [7:0] rank;
    logic [3:0] req;
    logic [3:0] grant;
    logic any;
    logic [1:0] served;
    logic [7:0] rotated;

    modport owner (output rank, output req, output served,
                   input grant, input any, input rotated);
    modport arbiter (input rank, input req, output grant, output any);
    modport rotator (input rank, input served, output rotated);
endinterface
`default_nettype wire

// >>> src/rank_arbiter.sv
// Picks the requesting slot with the best 2-bit rank code
`timescale 1ns/1ps
`default_nettype none
module rank_arbiter (
    rank_slot_if.arbiter slot
);
    always_comb begin
        logic found;
        found = 1'b0;
        slot.grant = 4'h0;
        for (int r = 0; r < 4; r++) begin
            for (int s = 0; s < 4; s++) begin
                if (!found && slot.req[s] && slot.rank[(3 - s) * 2 +: 2] == 2'(r)) begin
                    slot.grant[s] = 1'b1;
                    found = 1'b1;
                end
            end
        end
        slot.any = found;
    end
endmodule
`default_nettype wire

// >>> src/rank_rotator.sv
// Moves the served slot to the lowest rank and lifts the slots behind it
`timescale 1ns/1ps
`default_nettype none
module rank_rotator (
    rank_slot_if.rotator slot
);
    always_comb begin
        logic [1:0] served_code;
        logic [1:0] code;
        code = 2'h0;
        served_code = slot.rank[(3 - slot.served) * 2 +: 2];
        slot.rotated = 8'h00;
        for (int s = 0; s < 4; s++) begin
            code = slot.rank[(3 - s) * 2 +: 2];
            if (2'(s) == slot.served) begin
                slot.rotated[(3 - s) * 2 +: 2] = irq_status_pkg::RANK_LOWEST;
            end else if (code > served_code) begin
                slot.rotated[(3 - s) * 2 +: 2] = code - 2'h1;
            end else begin
                slot.rotated[(3 - s) * 2 +: 2] = code;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/irq_src_model.sv
// Peripheral interrupt sources that raise one-cycle request pulses on command
`timescale 1ns/1ps
`default_nettype none
module irq_src_model (
    // Clock
    input wire logic clk_sys_in,
    // Request lines towards the controller
    output logic [25:0] src_irq_out
);
    initial src_irq_out = 26'h0;
    task automatic pulse(input logic [25:0] bits);
        @(posedge clk_sys_in);
        src_irq_out <= bits;
        @(posedge clk_sys_in);
        src_irq_out <= 26'h0;
    endtask
endmodule
`default_nettype wire

// >>> testbench/irq_priority_status_and_service_clear_chk.sv
// Port-level assertions for the interrupt rank status and service clear block
`timescale 1ns/1ps
`default_nettype none
module irq_priority_status_and_service_clear_chk (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Interrupts
    input wire logic [25:0] src_irq_in,
    input wire logic irq_out,
    input wire logic fast_irq_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    // True when the byte holds four distinct 2-bit rank codes
    function automatic logic rank_set_ok(input logic [7:0] b);
        logic [3:0] seen;
        seen = 4'h0;
        for (int i = 0; i < 4; i++)
            seen[b[2 * i +: 2]] = 1'b1;
        return seen == 4'hf;
    endfunction
    function automatic logic is_mapped(input logic [31:0] a);
        return a inside {[32'h01e00010 : 32'h01e00024], 32'h01e0003c, 32'h01e00040,
            32'h01e00044, 32'h01e00048} && a[1:0] == 2'h0;
    endfunction
    sequence s_read(logic [31:0] a);
        psel_in && penable_in && pready_out && !pwrite_in && paddr_in == a;
    endsequence
    sequence s_clear_all;
        psel_in && penable_in && pready_out && pwrite_in && pwdata_in[25:0] == 26'h3ffffff
            && src_irq_in == 26'h0 && (paddr_in == irq_status_pkg::ADDR_NORMAL_CLEAR
            || paddr_in == irq_status_pkg::ADDR_FAST_CLEAR);
    endsequence
    property p_service_onehot;
        s_read(irq_status_pkg::ADDR_SERVICE) |-> $onehot0(prdata_out) && prdata_out[31:26] == 6'h0;
    endproperty
    a_service_onehot: assert property (p_service_onehot)
        else $error("service word holds more than one bit");
    property p_master_upper;
        s_read(irq_status_pkg::ADDR_CUR_MASTER_RANK) |-> prdata_out[31:14] == 18'h0;
    endproperty
    a_master_upper: assert property (p_master_upper)
        else $error("current master word upper bits not zero");
    property p_group_ranks;
        s_read(irq_status_pkg::ADDR_CUR_GROUP_RANK) |-> rank_set_ok(prdata_out[31:24])
            && rank_set_ok(prdata_out[23:16]) && rank_set_ok(prdata_out[15:8])
            && rank_set_ok(prdata_out[7:0]);
    endproperty
    a_group_ranks: assert property (p_group_ranks)
        else $error("current group ranks not four distinct codes");
    property p_master_ranks;
        s_read(irq_status_pkg::ADDR_CUR_MASTER_RANK) |-> rank_set_ok(prdata_out[7:0]);
    endproperty
    a_master_ranks: assert property (p_master_ranks)
        else $error("current master ranks not four distinct codes");
    property p_clear_reads_zero;
        s_read(irq_status_pkg::ADDR_NORMAL_CLEAR) or s_read(irq_status_pkg::ADDR_FAST_CLEAR)
            |-> prdata_out == 32'h0;
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero)
        else $error("clear register read is not zero");
    property p_clear_all_drops_lines;
        s_clear_all |-> ##2 (!irq_out && !fast_irq_out);
    endproperty
    a_clear_all_drops_lines: assert property (p_clear_all_drops_lines)
        else $error("interrupt line stays high after clearing every flag");
    property p_error_with_ready;
        pslverr_out |-> pready_out && psel_in && penable_in;
    endproperty
    a_error_with_ready: assert property (p_error_with_ready)
        else $error("slave error outside an access cycle");
    property p_unmapped_error;
        pready_out |-> pslverr_out == !is_mapped(paddr_in);
    endproperty
    a_unmapped_error: assert property (p_unmapped_error)
        else $error("slave error does not match the address map");
endmodule
bind irq_priority_status_and_service_clear irq_priority_status_and_service_clear_chk chk (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .src_irq_in(src_irq_in), .irq_out(irq_out),
    .fast_irq_out(fast_irq_out)
);
`default_nettype wire

// >>> testbench/test_irq_priority_status_and_service_clear.sv
// Self-checking bench for the interrupt rank status and service clear block
`timescale 1ns/1ps
`default_nettype none
module test_irq_priority_status_and_service_clear;
    typedef struct packed {logic [31:0] addr; logic [31:0] data; logic err;} row_type;
    // Reset contents of every register, then an unmapped word
    row_type rows [11] = '{
        '{32'h01e00010, 32'h1b1b1b1b, 1'b0}, '{32'h01e00014, 32'h00001f1b, 1'b0},
        '{32'h01e00018, 32'h1b1b1b1b, 1'b0}, '{32'h01e0001c, 32'h0000001b, 1'b0},
        '{32'h01e00020, 32'h00000000, 1'b0}, '{32'h01e00024, 32'h00000000, 1'b0},
        '{32'h01e0003c, 32'h00000000, 1'b0}, '{32'h01e00040, 32'h00000000, 1'b0},
        '{32'h01e00044, 32'h00000000, 1'b0}, '{32'h01e00048, 32'h00000000, 1'b0},
        '{32'h01e00028, 32'h00000000, 1'b1}};
    logic [25:0] order [3] = '{26'h2000000, 26'h0080000, 26'h0000001};
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [25:0] src_irq;
    logic pready, pslverr, irq, fast_irq, err;
    int failures = 0;
    int n_checks = 0;
    always #4 clk_sys_in = ~clk_sys_in;
    irq_priority_status_and_service_clear dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .src_irq_in(src_irq), .irq_out(irq),
        .fast_irq_out(fast_irq));
    irq_src_model src (.clk_sys_in(clk_sys_in), .src_irq_out(src_irq));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", {31'h0, pready}, 32'h1);
        if (pready !== 1'b1) begin
            end_sim;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].addr, 32'h0);
            check("pslverr", {31'h0, err}, {31'h0, rows[i].err});
            if (!rows[i].err) begin
                check("reset word", rd, rows[i].data);
            end
        end
        apb(1'b1, 32'h01e00018, 32'h0);
        rdc("current group rank", 32'h01e00018, 32'h1b1b1b1b);
        apb(1'b1, 32'h01e00010, 32'h1b1b1be4);
        idle(2);
        rdc("mirrored rank", 32'h01e00018, 32'h1b1b1be4);
        apb(1'b1, 32'h01e00010, 32'h1b1b1b1b);
        apb(1'b1, 32'h01e00044, 32'h03ffffff);
        src.pulse(26'h2000000);
        idle(2);
        check("irq line", {31'h0, irq}, 32'h1);
        rdc("service word", 32'h01e00020, 32'h02000000);
        apb(1'b0, 32'h01e0001c, 32'h0);
        check("vector", {26'h0, rd[13:8]}, 32'h19);
        // Further requests arrive while one is in service
        src.pulse(26'h0080001);
        idle(3);
        rdc("service held", 32'h01e00020, 32'h02000000);
        apb(1'b1, 32'h01e00040, 32'h0);
        rdc("pending", 32'h01e00040, 32'h02080001);
        apb(1'b1, 32'h01e00024, 32'h0);
        idle(3);
        rdc("pending kept", 32'h01e00040, 32'h02080001);
        rdc("reselected", 32'h01e00020, 32'h02000000);
        foreach (order[i]) begin
            apb(1'b1, 32'h01e00024, {6'h0, order[i]});
            idle(3);
            rdc("next service", 32'h01e00020, i < 2 ? {6'h0, order[i + 1]} : 32'h0);
        end
        check("irq idle", {31'h0, irq}, 32'h0);
        // Group A rotates, then the master level rotates
        apb(1'b1, 32'h01e00014, 32'h0000171b);
        src.pulse(26'h2000000);
        idle(2);
        apb(1'b1, 32'h01e00024, 32'h03ffffff);
        idle(3);
        rdc("rotated group", 32'h01e00018, 32'hc61b1b1b);
        apb(1'b0, 32'h01e0001c, 32'h0);
        check("fixed master", {24'h0, rd[7:0]}, 32'h1b);
        apb(1'b1, 32'h01e00014, 32'h0000071b);
        src.pulse(26'h0080000);
        idle(2);
        apb(1'b1, 32'h01e00024, 32'h03ffffff);
        idle(3);
        apb(1'b0, 32'h01e0001c, 32'h0);
        check("rotated master", {24'h0, rd[7:0]}, 32'h36);
        // Masked request, then the same request as a fast one
        apb(1'b1, 32'h01e00048, 32'h1);
        apb(1'b1, 32'h01e00044, 32'h0);
        src.pulse(26'h0000001);
        idle(3);
        check("masked lines", {30'h0, irq, fast_irq}, 32'h0);
        rdc("masked pending", 32'h01e00040, 32'h1);
        apb(1'b1, 32'h01e00044, 32'h1);
        idle(2);
        check("fast lines", {30'h0, irq, fast_irq}, 32'h1);
        rdc("fast service", 32'h01e00020, 32'h0);
        apb(1'b1, 32'h01e0003c, 32'h1);
        idle(3);
        check("fast line", {31'h0, fast_irq}, 32'h0);
        rdc("fast cleared", 32'h01e00040, 32'h0);
        // Reset in mid-run restores the ranks
        rst_n_in <= 1'b0;
        idle(2);
        rst_n_in <= 1'b1;
        idle(1);
        rdc("group after reset", 32'h01e00018, 32'h1b1b1b1b);
        rdc("master after reset", 32'h01e0001c, 32'h1b);
        end_sim;
    end
endmodule
`default_nettype wire
